// >>> ccm_pkg.sv
// constants and types for the completion credit manager
// assumes one user clock; pool counts are in credits, sizes in bytes
package ccm_pkg;

	// credit-tracking methods, in the order software writes them
	typedef enum logic [2:0] {
		FIXED_LIMIT_METHOD,
		PER_PACKET_METHOD,
		PER_BOUNDARY_METHOD,
		PER_DATA_CREDIT_METHOD,
		LINE_RATE_METHOD
	} ccm_method_t;

	// request kinds presented with each non-posted request
	localparam logic [1:0] KIND_MEM_RD = 2'h0;
	localparam logic [1:0] KIND_IO_RD = 2'h1;
	localparam logic [1:0] KIND_IO_WR = 2'h2;

	// register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_DATA_POOL = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_PENDING = 12'h00C;

	// control field positions
	localparam int CTRL_METHOD_LSB = 0;
	localparam int CTRL_USE_CFG_BIT = 3;
	localparam int CTRL_SCALE_LSB = 4;
	localparam int CTRL_DIGEST_BIT = 6;
	localparam int CTRL_RUNNING_BIT = 7;
	localparam int CTRL_IO_POLICY_BIT = 8;
	localparam int CTRL_RX_READY_BIT = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// completion receive space and defaults
	localparam logic [7:0] TOTAL_HEADER_POOL = 8'h24;
	localparam logic [15:0] TOTAL_DATA_POOL_RESET = 16'h004D;
	localparam logic [3:0] MAX_READ_SHIFT_DEFAULT = 4'h7;
	localparam logic [3:0] BOUNDARY_SHIFT_64 = 4'h6;
	localparam logic [3:0] BOUNDARY_SHIFT_128 = 4'h7;
	localparam logic [3:0] CREDIT_SHIFT = 4'h4;
	localparam logic [12:0] DIGEST_BYTES = 13'h0004;
	localparam logic [11:0] DWORD_BYTES = 12'h004;

endpackage

// >>> ccm_credit_manager.sv
// completion credit manager: admits non-posted requests to the core's
// transmit interface only while completion receive space remains, or in line-rate mode while receive ready is high.
// assumes completion headers are parsed upstream into start/beat strobes,
// all inputs on i_sys_clk; registers reached over an AHB-Lite slave port.
//
// Overview of operation
// [RULE1] header credits per max read: ceiling of max read size over boundary
// [RULE2] data pool packet capacity: floor of data pool over max read size
// [RULE3] header pool capacity by floor; limit is min of both capacities
// [RULE4] outstanding counter clears at reset and stays within zero..limit
// [RULE5] counter moves on each request sent and back after its last completion
// [RULE6] pending header and data credit counters clear at reset
// [RULE7] header need: ceiling of (address mod boundary plus size) over boundary
// [RULE8] data need: ceiling over 16 bytes; I/O write needs none
// [RULE9] admit only if both pools fit; add needs and remember them per tag
// [RULE10] per packet: release remembered needs after final completion data; code releases on the start strobe of the final completion
// [RULE11] per boundary: data credits per boundary is boundary over 16 bytes
// [RULE12] per boundary: release header and boundary data per boundary spanned
// [RULE13] boundaries spanned: ceiling of (lower address mod boundary plus length)
// [RULE14] alternative: running address advanced per dword counts each rollover
// [RULE15] optional: I/O read reserves one data credit, I/O write none, by tag
// [RULE16] per data credit: release one per 16-byte block spanned
// [RULE17] pool scaled by 2 or 4 to track in qwords or dwords
// [RULE18] line rate: issue reads freely only while receive ready held high
// [RULE19] core never overflows while receive ready is held asserted
// [RULE20] core has 36 header credits, data credits set by configuration
// [RULE21] max read size defaults to 128 bytes when config not used
// [RULE22] boundary from one config bit, 64 or 128 bytes, default 64
// [RULE23] a kept digest counts as completion payload
// [RULE24] admission and release in one cycle both reach the pending counters
`timescale 1ns/1ps
module ccm_credit_manager
	import ccm_pkg::*;
#(
	parameter int TAG_W = 5
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic o_hresp,
	// core configuration outputs
	input wire logic [2:0] i_cfg_max_read,
	input wire logic i_cfg_boundary_sel,
	// non-posted request from the user transmit path
	input wire logic i_req_valid,
	input wire logic [11:0] i_req_addr,
	input wire logic [12:0] i_req_len,
	input wire logic [1:0] i_req_kind,
	input wire logic [TAG_W-1:0] i_req_tag,
	output logic o_req_grant,
	// parsed completions from the receive path
	input wire logic i_cpl_start,
	input wire logic [6:0] i_cpl_lower_addr,
	input wire logic [12:0] i_cpl_len,
	input wire logic i_cpl_digest,
	input wire logic [TAG_W-1:0] i_cpl_tag,
	input wire logic i_cpl_final,
	input wire logic i_cpl_beat,
	input wire logic i_cpl_beat_last,
	// receive ready toward the core
	output logic o_rx_tready
);

	localparam int TAGS = 1 << TAG_W;

	////////////////////////////////////////////////////////////////////////////
	// registers and derived settings

	logic [31:0] ctrl_ff;
	logic [15:0] data_pool_ff;
	logic [7:0] outstanding_request_counter_ff;
	logic [7:0] pending_header_credit_count_ff;
	logic [15:0] pending_data_credit_count_ff;
	logic [11:0] running_address_ff;
	logic [1:0] run_kind_ff;
	logic grant_ff;

	ccm_method_t method;
	logic [1:0] scale;
	logic [3:0] max_read_sh;
	logic [3:0] boundary_sh;
	logic [3:0] unit_sh;
	logic [3:0] hdr_max_sh;
	logic [3:0] data_cap_sh;
	logic [17:0] total_data_pool;
	logic [7:0] header_pool_packet_capacity;
	logic [17:0] data_pool_packet_capacity;
	logic [7:0] outstanding_request_limit;
	logic [11:0] boundary_mask;
	logic [11:0] unit_mask;

	always_comb begin
		method = ccm_method_t'(ctrl_ff[CTRL_METHOD_LSB +: 3]);
		scale = ctrl_ff[CTRL_SCALE_LSB +: 2];
		if (scale == 2'h3) begin
			scale = 2'h2;
		end
		max_read_sh = MAX_READ_SHIFT_DEFAULT; // RULE21
		if (ctrl_ff[CTRL_USE_CFG_BIT] && i_cfg_max_read <= 3'h5) begin
			max_read_sh = MAX_READ_SHIFT_DEFAULT + {1'b0, i_cfg_max_read};
		end
		boundary_sh = BOUNDARY_SHIFT_64; // RULE22
		if (ctrl_ff[CTRL_USE_CFG_BIT] && i_cfg_boundary_sel) begin
			boundary_sh = BOUNDARY_SHIFT_128;
		end
		unit_sh = CREDIT_SHIFT - {2'h0, scale}; // RULE17
		total_data_pool = {2'h0, data_pool_ff} << scale; // RULE17
		boundary_mask = 12'((13'h0001 << boundary_sh) - 13'h0001);
		unit_mask = 12'((13'h0001 << unit_sh) - 13'h0001);
		hdr_max_sh = max_read_sh - boundary_sh; // RULE1
		data_cap_sh = max_read_sh - unit_sh;
		data_pool_packet_capacity = total_data_pool >> data_cap_sh; // RULE2
		header_pool_packet_capacity = TOTAL_HEADER_POOL >> hdr_max_sh; // RULE3 RULE20
		outstanding_request_limit = header_pool_packet_capacity; // RULE3
		if (data_pool_packet_capacity < {10'h000, header_pool_packet_capacity}) begin
			outstanding_request_limit = data_pool_packet_capacity[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request needs and admission

	logic [7:0] request_header_need;
	logic [11:0] request_data_need;
	logic [13:0] hdr_span;
	logic [13:0] data_span;
	logic admit;

	always_comb begin
		hdr_span = {2'h0, i_req_addr & boundary_mask} + {1'b0, i_req_len}
			+ {2'h0, boundary_mask};
		data_span = {2'h0, i_req_addr & unit_mask} + {1'b0, i_req_len}
			+ {2'h0, unit_mask};
		request_header_need = 8'(hdr_span >> boundary_sh); // RULE7
		request_data_need = 12'(data_span >> unit_sh); // RULE8
		if (method == PER_BOUNDARY_METHOD) begin
			request_data_need = 12'({4'h0, request_header_need}
				<< (boundary_sh - unit_sh)); // RULE11
			if (ctrl_ff[CTRL_IO_POLICY_BIT] && i_req_kind == KIND_IO_RD) begin
				request_data_need = 12'(12'h001 << scale); // RULE15
			end
		end
		if (i_req_kind == KIND_IO_WR) begin
			request_data_need = 12'h000; // RULE8 RULE15
		end
		admit = 1'b0;
		if (i_req_valid && !grant_ff) begin
			case (method)
				FIXED_LIMIT_METHOD: begin
					admit = outstanding_request_counter_ff < outstanding_request_limit; // RULE4
				end
				LINE_RATE_METHOD: begin
					admit = o_rx_tready; // RULE18
				end
				default: begin
					admit = ({1'b0, pending_header_credit_count_ff}
						+ {1'b0, request_header_need} <= {1'b0, TOTAL_HEADER_POOL})
						&& ({2'h0, pending_data_credit_count_ff}
						+ {6'h00, request_data_need} <= total_data_pool); // RULE9
				end
			endcase
		end
	end

	logic [7:0] hdr_need_mem [TAGS];
	logic [11:0] data_need_mem [TAGS];
	logic [1:0] kind_mem [TAGS];

	always_ff @(posedge i_sys_clk) begin
		if (admit) begin
			hdr_need_mem[i_req_tag] <= request_header_need; // RULE9
			data_need_mem[i_req_tag] <= request_data_need; // RULE9
			kind_mem[i_req_tag] <= i_req_kind; // RULE15
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			grant_ff <= 1'b0;
		end else begin
			grant_ff <= admit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion releases

	logic [7:0] rel_hdr;
	logic [15:0] rel_data;
	logic [12:0] cpl_len_eff;
	logic [13:0] cpl_hdr_span;
	logic [13:0] cpl_data_span;
	logic [7:0] boundary_crossings;
	logic [11:0] credit_block_crossings;
	logic [11:0] run_next;
	logic run_mode;
	logic io_read_cpl;
	logic io_write_cpl;

	always_comb begin
		cpl_len_eff = i_cpl_len;
		if (ctrl_ff[CTRL_DIGEST_BIT] && i_cpl_digest) begin
			cpl_len_eff = i_cpl_len + DIGEST_BYTES; // RULE23
		end
		cpl_hdr_span = {2'h0, {5'h00, i_cpl_lower_addr} & boundary_mask}
			+ {1'b0, cpl_len_eff} + {2'h0, boundary_mask};
		cpl_data_span = {2'h0, {5'h00, i_cpl_lower_addr} & unit_mask}
			+ {1'b0, cpl_len_eff} + {2'h0, unit_mask};
		boundary_crossings = 8'(cpl_hdr_span >> boundary_sh); // RULE13
		credit_block_crossings = 12'(cpl_data_span >> unit_sh); // RULE16
		run_mode = ctrl_ff[CTRL_RUNNING_BIT];
		run_next = running_address_ff + DWORD_BYTES;
		io_read_cpl = ctrl_ff[CTRL_IO_POLICY_BIT] && kind_mem[i_cpl_tag] == KIND_IO_RD;
		io_write_cpl = ctrl_ff[CTRL_IO_POLICY_BIT] && kind_mem[i_cpl_tag] == KIND_IO_WR;
		rel_hdr = 8'h00;
		rel_data = 16'h0000;
		case (method)
			PER_PACKET_METHOD: begin
				if (i_cpl_start && i_cpl_final) begin
					rel_hdr = hdr_need_mem[i_cpl_tag]; // RULE10
					rel_data = {4'h0, data_need_mem[i_cpl_tag]}; // RULE10
				end
			end
			PER_BOUNDARY_METHOD, PER_DATA_CREDIT_METHOD: begin
				if (i_cpl_start) begin
					rel_hdr = run_mode ? 8'h01 : boundary_crossings; // RULE12 RULE14
				end else if (run_mode && i_cpl_beat && !i_cpl_beat_last
					&& (run_next & boundary_mask) == 12'h000) begin
					rel_hdr = 8'h01; // RULE14
				end
				if (method == PER_BOUNDARY_METHOD) begin
					rel_data = 16'({8'h00, rel_hdr} << (boundary_sh - unit_sh)); // RULE12
					if (i_cpl_start && (io_read_cpl || io_write_cpl)) begin
						rel_data = {4'h0, data_need_mem[i_cpl_tag]}; // RULE15
					end else if (!i_cpl_start && run_kind_ff != KIND_MEM_RD) begin
						rel_data = 16'h0000; // RULE15
					end
				end else if (i_cpl_start) begin
					rel_data = run_mode ? 16'h0001 : {4'h0, credit_block_crossings}; // RULE16
				end else if (run_mode && i_cpl_beat && !i_cpl_beat_last
					&& (run_next & unit_mask) == 12'h000) begin
					rel_data = 16'h0001; // RULE16 RULE14
				end
			end
			default: begin
				rel_hdr = 8'h00;
				rel_data = 16'h0000;
			end
		endcase
	end

	// running address per completion, advanced one dword per beat
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			running_address_ff <= 12'h000;
			run_kind_ff <= KIND_MEM_RD;
		end else if (i_cpl_start) begin
			running_address_ff <= {5'h00, i_cpl_lower_addr}; // RULE14
			run_kind_ff <= (io_read_cpl || io_write_cpl) ? KIND_IO_RD : KIND_MEM_RD;
		end else if (i_cpl_beat) begin
			running_address_ff <= run_next; // RULE14
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outstanding and pending counters

	logic [8:0] hdr_sum;
	logic [16:0] data_sum;
	logic [7:0] nxt_pending_hdr;
	logic [15:0] nxt_pending_data;
	logic credit_method;

	always_comb begin
		credit_method = method == PER_PACKET_METHOD || method == PER_BOUNDARY_METHOD
			|| method == PER_DATA_CREDIT_METHOD;
		hdr_sum = {1'b0, pending_header_credit_count_ff};
		data_sum = {1'b0, pending_data_credit_count_ff};
		if (admit && credit_method) begin
			hdr_sum = hdr_sum + {1'b0, request_header_need}; // RULE24
			data_sum = data_sum + {5'h00, request_data_need}; // RULE24
		end
		nxt_pending_hdr = 8'h00;
		if (hdr_sum > {1'b0, rel_hdr}) begin
			nxt_pending_hdr = 8'(hdr_sum - {1'b0, rel_hdr}); // RULE24
		end
		nxt_pending_data = 16'h0000;
		if (data_sum > {1'b0, rel_data}) begin
			nxt_pending_data = 16'(data_sum - {1'b0, rel_data}); // RULE24
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pending_header_credit_count_ff <= 8'h00; // RULE6
			pending_data_credit_count_ff <= 16'h0000; // RULE6
		end else begin
			pending_header_credit_count_ff <= nxt_pending_hdr; // RULE9 RULE12
			pending_data_credit_count_ff <= nxt_pending_data; // RULE9 RULE16
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			outstanding_request_counter_ff <= 8'h00; // RULE4
		end else if (method == FIXED_LIMIT_METHOD) begin
			if (admit && !(i_cpl_start && i_cpl_final)) begin
				outstanding_request_counter_ff <= outstanding_request_counter_ff + 8'h01; // RULE5
			end else if (!admit && i_cpl_start && i_cpl_final
				&& outstanding_request_counter_ff != 8'h00) begin
				outstanding_request_counter_ff <= outstanding_request_counter_ff - 8'h01; // RULE5
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	logic wr_pend_ff;
	logic [11:0] wr_addr_ff;
	logic [31:0] rd_word;
	logic bus_take;

	assign bus_take = i_hsel && i_htrans[1] && i_hready;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (i_haddr[11:0] == REG_CTRL) begin
			rd_word = ctrl_ff;
		end else if (i_haddr[11:0] == REG_DATA_POOL) begin
			rd_word = {16'h0000, data_pool_ff};
		end else if (i_haddr[11:0] == REG_STATUS) begin
			rd_word = {16'h0000, outstanding_request_limit, outstanding_request_counter_ff};
		end else if (i_haddr[11:0] == REG_PENDING) begin
			rd_word = {8'h00, pending_header_credit_count_ff, pending_data_credit_count_ff};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
			o_hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= bus_take && i_hwrite;
			if (bus_take) begin
				wr_addr_ff <= i_haddr[11:0];
			end
			if (bus_take && !i_hwrite) begin
				o_hrdata <= rd_word;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_ff <= CTRL_RESET;
			data_pool_ff <= TOTAL_DATA_POOL_RESET;
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == REG_CTRL) begin
				ctrl_ff <= {22'h000000, i_hwdata[9:0]};
			end else if (wr_addr_ff == REG_DATA_POOL) begin
				data_pool_ff <= i_hwdata[15:0];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs toward the core's transaction interfaces

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_req_grant <= 1'b0;
			o_rx_tready <= 1'b0;
		end else begin
			o_req_grant <= admit;
			// held high in line-rate mode so the core cannot overflow
			o_rx_tready <= method == LINE_RATE_METHOD || ctrl_ff[CTRL_RX_READY_BIT]; // RULE18 RULE19
		end
	end

endmodule

// >>> ccm_monitor.sv
// port checker for the completion credit manager
// assumes hreadyout is looped back as the single slave's hready
`timescale 1ns/1ps
module ccm_monitor
	import ccm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic i_req_valid,
	input wire logic o_req_grant,
	input wire logic o_rx_tready
);
	logic dph_ff;
	logic wr_ff;
	logic [11:0] adr_ff;
	logic quiet_ff;
	logic rd;
	logic wr;
	assign rd = dph_ff & ~wr_ff & i_hready;
	assign wr = dph_ff & wr_ff & i_hready;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dph_ff <= 1'b0;
			wr_ff <= 1'b0;
			adr_ff <= 12'h000;
		end else if (i_hready) begin
			dph_ff <= i_hsel & i_htrans[1];
			wr_ff <= i_hwrite;
			adr_ff <= i_haddr[11:0];
		end
	end
	// no request admitted since reset
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			quiet_ff <= 1'b1;
		end else if (o_req_grant) begin
			quiet_ff <= 1'b0;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////
	property p_grant_pulse;
		o_req_grant |=> !o_req_grant;
	endproperty
	a_grant_pulse: assert property (p_grant_pulse)
		else $error("grant longer than one cycle");
	property p_grant_cause;
		o_req_grant |-> $past(i_req_valid) && !$past(o_req_grant);
	endproperty
	a_grant_cause: assert property (p_grant_cause)
		else $error("grant without a waiting request");
	property p_status_limit;
		rd && adr_ff == REG_STATUS |-> o_hrdata[7:0] <= o_hrdata[15:8];
	endproperty
	a_status_limit: assert property (p_status_limit)
		else $error("outstanding count above limit");
	property p_header_pool;
		rd && adr_ff == REG_PENDING |-> o_hrdata[23:16] <= TOTAL_HEADER_POOL;
	endproperty
	a_header_pool: assert property (p_header_pool)
		else $error("pending header credits above pool");
	property p_status_clear;
		rd && adr_ff == REG_STATUS && quiet_ff |-> o_hrdata[7:0] == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("outstanding count not clear after reset");
	property p_pending_clear;
		rd && adr_ff == REG_PENDING && quiet_ff |-> o_hrdata[23:0] == 24'h000000;
	endproperty
	a_pending_clear: assert property (p_pending_clear)
		else $error("pending credits not clear after reset");
	property p_ready_cause;
		$changed(o_rx_tready) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
	endproperty
	a_ready_cause: assert property (p_ready_cause)
		else $error("receive ready moved without a control write");
	property p_line_rate;
		wr && adr_ff == REG_CTRL && i_hwdata[2:0] == LINE_RATE_METHOD |-> ##[1:3] o_rx_tready;
	endproperty
	a_line_rate: assert property (p_line_rate)
		else $error("receive ready not held in line rate method");
endmodule
bind ccm_credit_manager ccm_monitor i_ccm_monitor (
	.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .i_req_valid(i_req_valid), .o_req_grant(o_req_grant),
	.o_rx_tready(o_rx_tready)
);

// >>> ccm_core_model.sv
// far side model: core receive path presenting parsed completions
// assumes the bench calls send_cpl, one completion at a time
`timescale 1ns/1ps
module ccm_core_model (
	input wire logic i_sys_clk,
	input wire logic i_rx_tready,
	output logic o_cpl_start,
	output logic [6:0] o_cpl_lower_addr,
	output logic [12:0] o_cpl_len,
	output logic [4:0] o_cpl_tag,
	output logic o_cpl_final,
	output logic o_cpl_digest,
	output logic o_cpl_beat,
	output logic o_cpl_beat_last
);
	initial begin
		o_cpl_start = 1'b0;
		o_cpl_lower_addr = 7'h00;
		o_cpl_len = 13'h0000;
		o_cpl_tag = 5'h00;
		o_cpl_final = 1'b0;
		o_cpl_digest = 1'b0;
		o_cpl_beat = 1'b0;
		o_cpl_beat_last = 1'b0;
	end
	task automatic send_cpl(input logic [6:0] la, input logic [12:0] ln, input logic [4:0] tg,
		input logic fin, input logic dg, input int nb);
		@(posedge i_sys_clk);
		// a completion starts only while the user side accepts it; its beats do not wait
		while (i_rx_tready !== 1'b1) @(posedge i_sys_clk);
		o_cpl_start <= 1'b1;
		o_cpl_lower_addr <= la;
		o_cpl_len <= ln;
		o_cpl_tag <= tg;
		o_cpl_final <= fin;
		o_cpl_digest <= dg;
		@(posedge i_sys_clk);
		o_cpl_start <= 1'b0;
		o_cpl_lower_addr <= ~la;
		o_cpl_len <= ~ln;
		o_cpl_tag <= ~tg;
		o_cpl_final <= ~fin;
		o_cpl_digest <= ~dg;
		// payload dwords follow the start cycle
		for (int k = 0; k < nb; k++) begin
			o_cpl_beat <= 1'b1;
			o_cpl_beat_last <= (k == nb - 1);
			@(posedge i_sys_clk);
		end
		o_cpl_beat <= 1'b0;
		o_cpl_beat_last <= 1'b0;
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the completion credit manager
// assumes this bench is the only AHB master and the core model the far side
`timescale 1ns/1ps
module tb_top
	import ccm_pkg::*;
;
	logic clk;
	logic resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, grant, tready, cfg_sel = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, gcnt = 32'h0, g0;
	logic [1:0] htrans = 2'h0, req_kind = 2'h0;
	logic [2:0] cfg_max = 3'h0;
	logic req_valid = 1'b0, cpl_start, cpl_fin, cpl_dg, cpl_beat, cpl_blast, hresp;
	logic [11:0] req_addr = 12'h000;
	logic [12:0] req_len = 13'h0, cpl_len;
	logic [4:0] req_tag = 5'h0, cpl_tag;
	logic [6:0] cpl_la;
	logic [2:0] mx [4] = '{3'h1, 3'h5, 3'h5, 3'h0};
	logic sl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic [31:0] cw [4] = '{32'h208, 32'h208, 32'h200, 32'h208};
	logic [15:0] pl [4] = '{16'h4D, 16'h4D, 16'h9A, 16'h4D};
	logic [7:0] lm [4] = '{8'h04, 8'h00, 8'h12, 8'h09};
	int num_errors = 0;
	int checks = 0;
	ccm_credit_manager i_ccm_credit_manager (
		.i_sys_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
		.i_cfg_max_read(cfg_max), .i_cfg_boundary_sel(cfg_sel), .i_req_valid(req_valid),
		.i_req_addr(req_addr), .i_req_len(req_len), .i_req_kind(req_kind), .i_req_tag(req_tag),
		.o_req_grant(grant), .i_cpl_start(cpl_start), .i_cpl_lower_addr(cpl_la),
		.i_cpl_len(cpl_len), .i_cpl_digest(cpl_dg), .i_cpl_tag(cpl_tag), .i_cpl_final(cpl_fin),
		.i_cpl_beat(cpl_beat), .i_cpl_beat_last(cpl_blast), .o_rx_tready(tready)
	);
	ccm_core_model i_ccm_core_model (
		.i_sys_clk(clk), .i_rx_tready(tready), .o_cpl_start(cpl_start),
		.o_cpl_lower_addr(cpl_la), .o_cpl_len(cpl_len), .o_cpl_tag(cpl_tag),
		.o_cpl_final(cpl_fin), .o_cpl_digest(cpl_dg), .o_cpl_beat(cpl_beat),
		.o_cpl_beat_last(cpl_blast)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (grant === 1'b1) gcnt <= gcnt + 32'h1;
	////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic do_reset;
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rdat = hrdata;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		check($sformatf("register %h", a), rdat, e);
		check("response", {31'h0, hresp}, 32'h0);
	endtask
	task automatic req(input logic [11:0] a, input logic [12:0] l, input logic [1:0] k,
		input logic [4:0] t);
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr <= a;
		req_len <= l;
		req_kind <= k;
		req_tag <= t;
		do @(posedge clk); while (grant !== 1'b1);
		req_valid <= 1'b0;
		req_addr <= ~a;
		req_len <= ~l;
	endtask
	task automatic cpl(input logic [6:0] la, input logic [12:0] ln, input logic [4:0] t,
		input logic f);
		i_ccm_core_model.send_cpl(la, ln, t, f, 1'b0, 0);
	endtask
	// waiting request must stay refused until tag t completes
	task automatic held(input logic [4:0] t);
		logic [31:0] g;
		g = gcnt;
		repeat (12) @(posedge clk);
		check("grant while full", gcnt, g);
		cpl(7'h00, 13'h0004, t, 1'b1);
	endtask
	initial begin
		repeat (10000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		do_reset();
		rchk(REG_CTRL, CTRL_RESET);
		rchk(REG_DATA_POOL, 32'h0000_004D);
		rchk(REG_STATUS, 32'h0000_0900);
		rchk(REG_PENDING, 32'h0);
		rchk(12'h010, 32'h0);
		bus(REG_CTRL, 1'b1, 32'hFFFF_FC01);
		rchk(REG_CTRL, 32'h0000_0001);
		bus(REG_CTRL, 1'b1, 32'h0000_0200);
		for (int i = 0; i < 9; i++) req(12'h000, 13'h0004, KIND_MEM_RD, 5'(i));
		rchk(REG_STATUS, 32'h0000_0909);
		cpl(7'h00, 13'h0004, 5'h00, 1'b0);
		rchk(REG_STATUS, 32'h0000_0909);
		fork
			req(12'h000, 13'h0004, KIND_MEM_RD, 5'h09);
			held(5'h00);
		join
		for (int i = 1; i < 10; i++) cpl(7'h00, 13'h0004, 5'(i), 1'b1);
		rchk(REG_STATUS, 32'h0000_0900);
		for (int i = 0; i < 4; i++) begin
			cfg_max <= mx[i];
			cfg_sel <= sl[i];
			bus(REG_DATA_POOL, 1'b1, {16'h0000, pl[i]});
			bus(REG_CTRL, 1'b1, cw[i]);
			rchk(REG_STATUS, {16'h0000, lm[i], 8'h00});
		end
		bus(REG_DATA_POOL, 1'b1, 32'h0000_004D);
		bus(REG_CTRL, 1'b1, 32'h0000_0201);
		req(12'h07C, 13'h0008, KIND_MEM_RD, 5'h00);
		rchk(REG_PENDING, 32'h0002_0002);
		req(12'h000, 13'h0004, KIND_IO_WR, 5'h01);
		rchk(REG_PENDING, 32'h0003_0002);
		cpl(7'h7C, 13'h0008, 5'h00, 1'b1);
		rchk(REG_PENDING, 32'h0001_0000);
		cpl(7'h00, 13'h0004, 5'h01, 1'b1);
		req(12'h000, 13'h04D0, KIND_MEM_RD, 5'h02);
		rchk(REG_PENDING, 32'h0014_004D);
		fork
			req(12'h000, 13'h0004, KIND_MEM_RD, 5'h03);
			held(5'h02);
		join
		fork
			req(12'h000, 13'h0004, KIND_MEM_RD, 5'h04);
			cpl(7'h00, 13'h0004, 5'h03, 1'b1);
		join
		rchk(REG_PENDING, 32'h0001_0001);
		cpl(7'h00, 13'h0004, 5'h04, 1'b1);
		bus(REG_CTRL, 1'b1, 32'h0000_0202);
		req(12'h000, 13'h0100, KIND_MEM_RD, 5'h05);
		rchk(REG_PENDING, 32'h0004_0010);
		cpl(7'h20, 13'h0040, 5'h05, 1'b0);
		rchk(REG_PENDING, 32'h0002_0008);
		cpl(7'h60, 13'h0020, 5'h05, 1'b0);
		rchk(REG_PENDING, 32'h0001_0004);
		cpl(7'h00, 13'h0040, 5'h05, 1'b1);
		rchk(REG_PENDING, 32'h0);
		bus(REG_CTRL, 1'b1, 32'h0000_0302);
		req(12'h000, 13'h0004, KIND_IO_RD, 5'h0A);
		rchk(REG_PENDING, 32'h0001_0001);
		cpl(7'h00, 13'h0004, 5'h0A, 1'b1);
		rchk(REG_PENDING, 32'h0);
		req(12'h000, 13'h0004, KIND_MEM_RD, 5'h0B);
		cpl(7'h00, 13'h0004, 5'h0B, 1'b1);
		rchk(REG_PENDING, 32'h0);
		bus(REG_CTRL, 1'b1, 32'h0000_0203);
		req(12'h07C, 13'h0008, KIND_MEM_RD, 5'h06);
		cpl(7'h7C, 13'h0004, 5'h06, 1'b0);
		rchk(REG_PENDING, 32'h0001_0001);
		cpl(7'h00, 13'h0004, 5'h06, 1'b1);
		bus(REG_CTRL, 1'b1, 32'h0000_0223);
		req(12'h002, 13'h0008, KIND_MEM_RD, 5'h07);
		rchk(REG_PENDING, 32'h0001_0003);
		cpl(7'h02, 13'h0008, 5'h07, 1'b1);
		rchk(REG_PENDING, 32'h0);
		bus(REG_CTRL, 1'b1, 32'h0000_0283);
		req(12'h030, 13'h0010, KIND_MEM_RD, 5'h08);
		req(12'h000, 13'h0040, KIND_MEM_RD, 5'h09);
		rchk(REG_PENDING, 32'h0002_0005);
		i_ccm_core_model.send_cpl(7'h30, 13'h0010, 5'h08, 1'b1, 1'b0, 4);
		rchk(REG_PENDING, 32'h0001_0004);
		bus(REG_CTRL, 1'b1, 32'h0000_0243);
		i_ccm_core_model.send_cpl(7'h00, 13'h0010, 5'h09, 1'b1, 1'b1, 0);
		rchk(REG_PENDING, 32'h0000_0002);
		bus(REG_CTRL, 1'b1, 32'h0000_0000);
		repeat (3) @(posedge clk);
		check("rx ready", {31'h0, tready}, 32'h0);
		bus(REG_CTRL, 1'b1, 32'h0000_0004);
		repeat (3) @(posedge clk);
		check("rx ready", {31'h0, tready}, 32'h1);
		g0 = gcnt;
		for (int i = 0; i < 12; i++) req(12'h000, 13'h0004, KIND_MEM_RD, 5'(i + 8));
		@(posedge clk);
		check("line rate grants", gcnt - g0, 32'h0000_000C);
		do_reset();
		rchk(REG_STATUS, 32'h0000_0900);
		rchk(REG_CTRL, CTRL_RESET);
		give_verdict();
	end
endmodule
